// file: core/t1_tx_sync_pkg.sv
// Constants and types for the T1 transmit frame synchronizer.
// Assumes one framer instance per package user.
`default_nettype none
package t1_tx_sync_pkg;
    // Bus geometry
    localparam int ADDR_W = 14;
    localparam int IDX_W  = 12;
    // Register indices (byte address is four times the index)
    localparam logic [11:0] CTRL_THREE_IDX  = 12'h183;
    localparam logic [11:0] IO_CONFIG_IDX   = 12'h184;
    localparam logic [11:0] RESYNC_CTRL_IDX = 12'h18E;
    localparam logic [11:0] LATCHED_IDX     = 12'h192;
    localparam logic [11:0] LIVE_IDX        = 12'h196;
    localparam logic [11:0] IRQ_MASK_IDX    = 12'h1A2;
    localparam logic [11:0] FRAMER_STRIDE   = 12'h200;
    // Field positions
    localparam int FORMAT_BIT   = 2;
    localparam int PULSE_SEL_BIT = 0;
    localparam int DIR_BIT      = 2;
    localparam int THRESH_LSB   = 0;
    localparam int RESYNC_BIT   = 2;
    localparam int LOSS_BIT     = 0;
    localparam int SEARCH_BIT   = 0;
    localparam int IDLE_BIT     = 1;
    // Reset values
    localparam logic [7:0] CTRL_THREE_RST  = 8'h00;
    localparam logic [7:0] IO_CONFIG_RST   = 8'h00;
    localparam logic [7:0] RESYNC_CTRL_RST = 8'h01;
    localparam logic [7:0] IRQ_MASK_RST    = 8'h00;
    // Framing geometry
    localparam logic [7:0] LAST_BIT      = 8'hC0;
    localparam logic [4:0] D4_LAST_FRAME  = 5'h0B;
    localparam logic [4:0] ESF_LAST_FRAME = 5'h17;
    // D4 F-bit sequence, frame 1 in bit 0
    localparam logic [11:0] D4_PATTERN = 12'h3B1;
    // ESF FPS sequence, frame 4 in bit 0
    localparam logic [5:0] ESF_FPS = 6'h34;
    localparam int SYNC_HITS = 6;
    // Synchronizer states, Gray along idle-hunt-sync
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HUNT = 2'b01,
        ST_SYNC = 2'b11
    } sync_state_t;
    // Two-way pin drive
    typedef struct packed {
        logic out;
        logic oe_n;
    } pin_drive_t;
    // Decoded configuration
    typedef struct packed {
        logic       esf;
        logic       mfPulse;
        logic       pinOut;
        logic [1:0] errThresh;
    } sync_cfg_t;
endpackage
`default_nettype wire

// file: core/t1_tx_sync.sv
// Transmit frame synchronizer for one T1 framer, with Avalon-MM registers.
// Assumes serial data and its bit strobe are synchronous to sys_clk.
`default_nettype none

// Summary of operation
// - Find frame and multiframe boundaries in serial input
// - Format bit picks D4 or ESF search
// - Resync control register sets loss and resync
// - Latch frame loss status on sync loss
// - Live flag high while hunting alignment
// - Unmasked latched loss drives low interrupt
// - Frame pulse on sync pin when output
// - Pulse select gives multiframe pulse instead
// - Idle while elastic store or interleaved mode
// - Framing pattern only, no CRC checks
// - No signaling multiframe search
// - Framer registers offset by framer stride
module t1_tx_sync #(
    parameter int FRAMER_INDEX = 1,
    parameter int SYNC_HITS    = t1_tx_sync_pkg::SYNC_HITS
) (
    // Clock and reset
    input  wire logic                      sys_clk,
    input  wire logic                      rst_n,
    // Avalon-MM slave
    input  wire logic [t1_tx_sync_pkg::ADDR_W-1:0] avs_address,
    input  wire logic                      avs_read,
    input  wire logic                      avs_write,
    input  wire logic [31:0]               avs_writedata,
    input  wire logic [3:0]                avs_byteenable,
    output logic      [31:0]               avs_readdata,
    output logic                           avs_waitrequest,
    // Serial system data
    input  wire logic                      txSerialIn,
    input  wire logic                      txBitStrobe,
    // Elastic store state
    input  wire logic                      elasticStoreEn,
    input  wire logic                      interleaved_bus_mode,
    // Sync pin, flags and interrupt
    input  wire logic                      txFramePulseIn,
    output t1_tx_sync_pkg::pin_drive_t     tx_frame_pulse_pin,
    output logic                           tx_frame_search_live,
    output logic                           interrupt_out_n
);
    import t1_tx_sync_pkg::*;

    // Framer base index
    localparam logic [IDX_W-1:0] BASE =
        IDX_W'(int'(FRAMER_STRIDE) * (FRAMER_INDEX - 1));
    localparam logic [2:0] HITS_LAST = 3'(SYNC_HITS - 1);

    // Register select codes
    localparam logic [2:0] SEL_NONE = 3'h0;
    localparam logic [2:0] SEL_CTRL = 3'h1;
    localparam logic [2:0] SEL_IO   = 3'h2;
    localparam logic [2:0] SEL_RSC  = 3'h3;
    localparam logic [2:0] SEL_LAT  = 3'h4;
    localparam logic [2:0] SEL_LIVE = 3'h5;
    localparam logic [2:0] SEL_MASK = 3'h6;

    // Address to register select
    function automatic logic [2:0] regSel(
        input logic [ADDR_W-1:0] addr);
        logic [IDX_W-1:0] idx;
        idx = addr[ADDR_W-1:2] - BASE;
        unique case (idx)
            CTRL_THREE_IDX:  regSel = SEL_CTRL;
            IO_CONFIG_IDX:   regSel = SEL_IO;
            RESYNC_CTRL_IDX: regSel = SEL_RSC;
            LATCHED_IDX:     regSel = SEL_LAT;
            LIVE_IDX:        regSel = SEL_LIVE;
            IRQ_MASK_IDX:    regSel = SEL_MASK;
            default:         regSel = SEL_NONE;
        endcase
    endfunction

    // Expected F bit: {checked, value}
    function automatic logic [1:0] fExpect(
        input logic esf, input logic [4:0] frame);
        if (!esf) begin
            fExpect = {1'b1, D4_PATTERN[frame[3:0]]};
        end else if (frame[1:0] == 2'h3) begin
            // Only FPS frames; CRC and link bits skipped
            fExpect = {1'b1, ESF_FPS[frame[4:2]]};
        end else begin
            fExpect = 2'b00;
        end
    endfunction

    // Registers seen by software
    logic [7:0]  ctrlThree;      // Format select lives here
    logic [7:0]  ioConfig;       // Pin direction, pulse select
    logic [7:0]  resyncCtrl;     // Loss threshold, resync
    logic        lossLatched;    // Sticky frame loss
    logic [7:0]  irqMask;        // Interrupt enables
    logic        ack;            // Second cycle of access
    logic [31:0] readData;       // Held read word
    logic        irqN;           // Registered interrupt

    logic [7:0]  next_ctrlThree;
    logic [7:0]  next_ioConfig;
    logic [7:0]  next_resyncCtrl;
    logic        next_lossLatched;
    logic [7:0]  next_irqMask;
    logic        next_ack;
    logic [31:0] next_readData;
    logic        next_irqN;

    // Synchronizer state
    sync_state_t state;
    sync_state_t next_state;
    logic [7:0]  bitPos;         // Bit within frame
    logic [7:0]  next_bitPos;
    logic [4:0]  framePos;       // Frame within multiframe
    logic [4:0]  next_framePos;
    logic [2:0]  hits;           // Good F bits in hunt
    logic [2:0]  next_hits;
    logic [2:0]  errs;           // Bad F bits in a row
    logic [2:0]  next_errs;
    logic        pulse;          // Recovered pulse
    logic        next_pulse;
    logic        lossEvent;      // Sync dropped this cycle

    // Decoded bus terms
    sync_cfg_t   cfg;
    logic        busReq;
    logic        accept;
    logic        wrLow;
    logic        rdLatch;
    logic        resyncReq;
    logic        disabled;
    logic [2:0]  sel;
    logic [1:0]  fx;
    logic        fBit;

    assign busReq  = avs_read | avs_write;
    // Accept on the edge where waitrequest is low
    assign accept  = busReq & ack;
    assign sel     = regSel(avs_address);
    assign wrLow   = avs_write & accept & avs_byteenable[0];
    assign rdLatch = avs_read & accept & (sel == SEL_LAT);
    // Writing one to the resync bit asks for a new hunt
    assign resyncReq = wrLow & (sel == SEL_RSC)
                     & avs_writedata[RESYNC_BIT];
    // Elastic store paths bypass the synchronizer
    assign disabled = elasticStoreEn
                    | interleaved_bus_mode;

    assign cfg.esf       = ctrlThree[FORMAT_BIT];
    assign cfg.mfPulse   = ioConfig[PULSE_SEL_BIT];
    assign cfg.pinOut    = ioConfig[DIR_BIT];
    assign cfg.errThresh = resyncCtrl[THRESH_LSB+1:THRESH_LSB];

    assign fx   = fExpect(cfg.esf, framePos);
    // A framing bit position that is checked
    assign fBit = txBitStrobe & (bitPos == 8'h00) & fx[1];

    // Outputs
    assign avs_waitrequest = busReq & ~ack;
    assign avs_readdata    = readData;
    assign interrupt_out_n = irqN;
    assign tx_frame_search_live = (state == ST_HUNT);
    // Pin drives only when software made it an output
    assign tx_frame_pulse_pin.out  = pulse;
    assign tx_frame_pulse_pin.oe_n = ~cfg.pinOut;

    // Register file next values
    always_comb begin
        next_ctrlThree  = ctrlThree;
        next_ioConfig   = ioConfig;
        next_resyncCtrl = resyncCtrl;
        next_irqMask    = irqMask;
        next_readData   = readData;
        // One wait state keeps read data from a flop
        next_ack        = busReq & ~ack;
        if (wrLow) begin
            unique case (sel)
                SEL_CTRL: next_ctrlThree = avs_writedata[7:0];
                SEL_IO:   next_ioConfig  = avs_writedata[7:0];
                SEL_RSC: begin
                    // Resync bit is a strobe and reads zero
                    next_resyncCtrl = avs_writedata[7:0];
                    next_resyncCtrl[RESYNC_BIT] = 1'b0;
                end
                SEL_MASK: next_irqMask = avs_writedata[7:0];
                default: ;
            endcase
        end
        if (busReq & ~ack) begin
            next_readData = 32'h0000_0000;
            unique case (sel)
                SEL_CTRL: next_readData[7:0] = ctrlThree;
                SEL_IO:   next_readData[7:0] = ioConfig;
                SEL_RSC:  next_readData[7:0] = resyncCtrl;
                SEL_LAT:  next_readData[LOSS_BIT] = lossLatched;
                SEL_LIVE: begin
                    next_readData[SEARCH_BIT] = (state == ST_HUNT);
                    next_readData[IDLE_BIT]   = (state == ST_IDLE);
                end
                SEL_MASK: next_readData[7:0] = irqMask;
                default:  next_readData = 32'h0000_0000;
            endcase
        end
        // A loss in the clearing cycle still sets the bit
        next_lossLatched = (lossLatched & ~rdLatch)
                         | lossEvent;
        next_irqN = ~(next_lossLatched
                  & next_irqMask[LOSS_BIT]);
    end

    // Register file flops
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ctrlThree   <= CTRL_THREE_RST;
            ioConfig    <= IO_CONFIG_RST;
            resyncCtrl  <= RESYNC_CTRL_RST;
            lossLatched <= 1'b0;
            irqMask     <= IRQ_MASK_RST;
            ack         <= 1'b0;
            readData    <= 32'h0000_0000;
            irqN        <= 1'b1;
        end else begin
            ctrlThree   <= next_ctrlThree;
            ioConfig    <= next_ioConfig;
            resyncCtrl  <= next_resyncCtrl;
            lossLatched <= next_lossLatched;
            irqMask     <= next_irqMask;
            ack         <= next_ack;
            readData    <= next_readData;
            irqN        <= next_irqN;
        end
    end

    // Frame search; only F-bit patterns, no signaling
    // multiframe, so a CAS boundary is never reported
    always_comb begin
        next_state    = state;
        next_bitPos   = bitPos;
        next_framePos = framePos;
        next_hits     = hits;
        next_errs     = errs;
        next_pulse    = pulse;
        lossEvent     = 1'b0;
        // Count bits and frames on each strobe
        if (txBitStrobe) begin
            next_bitPos = (bitPos == LAST_BIT) ? 8'h00
                        : bitPos + 8'h01;
            if (bitPos == LAST_BIT) begin
                if (framePos == (cfg.esf ? ESF_LAST_FRAME
                                         : D4_LAST_FRAME)) begin
                    next_framePos = 5'h00;
                end else begin
                    next_framePos = framePos + 5'h01;
                end
            end
            // Pulse lasts one bit time at the F bit
            next_pulse = (state == ST_SYNC) & (bitPos == 8'h00)
                & (~cfg.mfPulse | (framePos == 5'h00));
        end
        unique case (state)
            ST_IDLE: begin
                next_hits   = 3'h0;
                next_errs   = 3'h0;
                next_pulse  = 1'b0;
                next_state  = ST_HUNT;
            end
            ST_HUNT: begin
                if (fBit) begin
                    if (txSerialIn == fx[0]) begin
                        next_hits = hits + 3'h1;
                        if (hits == HITS_LAST) begin
                            next_state = ST_SYNC;
                            next_errs  = 3'h0;
                        end
                    end else begin
                        // Slip one bit: try the next position
                        next_bitPos = bitPos;
                        next_hits   = 3'h0;
                    end
                end
            end
            ST_SYNC: begin
                if (fBit) begin
                    if (txSerialIn == fx[0]) begin
                        next_errs = 3'h0;
                    end else begin
                        next_errs = errs + 3'h1;
                        // Threshold field holds errors minus one
                        if (errs[1:0] == cfg.errThresh) begin
                            next_state = ST_HUNT;
                            next_hits  = 3'h0;
                            lossEvent  = 1'b1;
                        end
                    end
                end
                if (resyncReq) begin
                    next_state = ST_HUNT;
                    next_hits  = 3'h0;
                    lossEvent  = 1'b1;
                end
            end
            default: next_state = ST_IDLE;
        endcase
        // Disable overrides the state, the pulse and the loss event
        if (disabled) begin
            next_state = ST_IDLE;
            next_pulse = 1'b0;
            lossEvent  = 1'b0;
        end
    end

    // Synchronizer flops
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state    <= ST_IDLE;
            bitPos   <= 8'h00;
            framePos <= 5'h00;
            hits     <= 3'h0;
            errs     <= 3'h0;
            pulse    <= 1'b0;
        end else begin
            state    <= next_state;
            bitPos   <= next_bitPos;
            framePos <= next_framePos;
            hits     <= next_hits;
            errs     <= next_errs;
            pulse    <= next_pulse;
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // F bit seen while locked
    sequence fStrobeSync;
        txBitStrobe && bitPos == 8'h00 && state == ST_SYNC
            && !disabled;
    endsequence

    // Loss flag follows a good-to-bad step
    sequence dropSeq;
        state == ST_SYNC ##1 state == ST_HUNT;
    endsequence

    loss_sets_latch_a: assert property (
        dropSeq |-> lossLatched)
        else $error("loss not latched");

    latch_holds_a: assert property (
        lossLatched && !rdLatch |=> lossLatched)
        else $error("latched loss dropped");

    irq_mask_a: assert property (
        interrupt_out_n == !(lossLatched && irqMask[LOSS_BIT]))
        else $error("interrupt not raised");

    sync_entry_a: assert property (
        state == ST_HUNT && next_state == ST_SYNC
            |-> hits == HITS_LAST && fBit)
        else $error("sync entered early");

    search_flag_a: assert property (
        dropSeq |-> tx_frame_search_live)
        else $error("search flag low while hunting");

    disable_idle_a: assert property (
        disabled |=> state == ST_IDLE && !pulse)
        else $error("runs with elastic store");

    frame_pulse_a: assert property (
        fStrobeSync ##0 !cfg.mfPulse |=> pulse)
        else $error("frame pulse missing");

    mf_pulse_a: assert property (
        fStrobeSync ##0 cfg.mfPulse && framePos != 5'h00
            |=> !pulse)
        else $error("pulse off multiframe");

    resync_hunt_a: assert property (
        resyncReq && state == ST_SYNC && !disabled
            |=> state == ST_HUNT)
        else $error("resync ignored");

    esf_skip_a: assert property (
        fStrobeSync ##0 cfg.esf && framePos[1:0] != 2'h3
            && !resyncReq |=> state == ST_SYNC)
        else $error("non-FPS bit checked");

    mask_write_a: assert property (
        wrLow && sel == SEL_MASK
            |=> irqMask == $past(avs_writedata[7:0]))
        else $error("mask write lost");

    bus_answer_a: assert property (
        busReq && !ack |=> !avs_waitrequest)
        else $error("no answer in one cycle");

endmodule // t1_tx_sync
`default_nettype wire

// file: tb/tx_serial_source.sv
// Model of the system-side logic that feeds framed serial data.
// Assumes the sys_clk domain; one bit strobe every STB_PERIOD cycles.
`default_nettype none
module tx_serial_source
    import t1_tx_sync_pkg::*;
#(
    parameter int STB_PERIOD = 2
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // Control from the bench
    input  wire logic esfMode,
    input  wire logic badFraming,
    // Serial output
    output logic      txSerialIn,
    output logic      txBitStrobe
);
    timeunit 1ns;
    timeprecision 1ps;
    int   phase;   // Cycles since the last strobe
    int   bitCnt;  // Bit within the frame, 0 is the F bit
    int   frame;   // Frame within the multiframe, from 0
    logic curBit;  // Bit handed out at this strobe

    // F bits follow the framing sequence; ESF CRC bits are left as junk
    always_comb begin
        if (bitCnt == 0 && !esfMode) begin
            curBit = D4_PATTERN[frame % 12] ^ badFraming;
        end else if (bitCnt == 0 && frame % 4 == 3) begin
            curBit = ESF_FPS[frame / 4] ^ badFraming;
        end else begin
            curBit = bitCnt[0] ^ bitCnt[2] ^ frame[0];
        end
    end

    // Data is only valid in the strobe cycle, inverted otherwise
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            phase       <= 0;
            bitCnt      <= 0;
            frame       <= 0;
            txBitStrobe <= 1'b0;
            txSerialIn  <= 1'b0;
        end else begin
            phase       <= (phase == STB_PERIOD - 1) ? 0 : phase + 1;
            txBitStrobe <= (phase == 0);
            if (phase == 0) begin
                txSerialIn <= curBit;
                bitCnt     <= (bitCnt == 192) ? 0 : bitCnt + 1;
                if (bitCnt == 192) begin
                    frame <= (frame >= (esfMode ? 23 : 11)) ? 0 : frame + 1;
                end
            end else begin
                txSerialIn <= ~txSerialIn;
            end
        end
    end
endmodule // tx_serial_source
`default_nettype wire

// file: tb/t1_transmit_frame_synchronizer_bench.sv
// Self-checking bench for the transmit frame synchronizer.
// Assumes the package and the serial source model are compiled first.
`default_nettype none
`define CHK(got, exp) begin nCompared++; if ((got) !== (exp)) begin \
    nMismatch++; $display("BAD %0t got %0h exp %0h", $time, got, exp); end end
module t1_transmit_frame_synchronizer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import t1_tx_sync_pkg::*;
    localparam int FRAMER    = 2;        // Second framer exercises the stride
    localparam int HITS      = 4;        // Short sync count for quick runs
    localparam int STB       = 2;        // Cycles per serial bit
    localparam int FRAME_CYC = 193 * STB;
    logic              sys_clk = 1'b0;
    logic              rst_n = 1'b0;
    logic [ADDR_W-1:0] avs_address = '0;
    logic              avs_read = 1'b0;
    logic              avs_write = 1'b0;
    logic [31:0]       avs_writedata = '0;
    logic [3:0]        avs_byteenable = '0;
    logic [31:0]       avs_readdata;
    logic              avs_waitrequest;
    logic              serialBit, bitStrobe, searchLive, irqN;
    pin_drive_t        pin;
    logic              esfMode = 1'b0, badFraming = 1'b0;
    logic              elasticOn = 1'b0, interleavedBus = 1'b0;
    logic [7:0]        rd;                // Last read data
    int                nMismatch = 0;
    int                nCompared = 0;
    int                cyc = 0;           // Free cycle count

    // Clock and cycle count
    always #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= cyc + 1;

    t1_tx_sync #(.FRAMER_INDEX(FRAMER), .SYNC_HITS(HITS)) uut (
        .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .txSerialIn(serialBit), .txBitStrobe(bitStrobe),
        .elasticStoreEn(elasticOn), .interleaved_bus_mode(interleavedBus),
        .txFramePulseIn(1'b0), .tx_frame_pulse_pin(pin),
        .tx_frame_search_live(searchLive), .interrupt_out_n(irqN));

    // Source shares the bench reset, so its bit and frame counts track
    // the block's; a restart of its own would leave the block misaligned
    tx_serial_source #(.STB_PERIOD(STB)) src (
        .sys_clk(sys_clk), .rst_n(rst_n), .esfMode(esfMode),
        .badFraming(badFraming), .txSerialIn(serialBit),
        .txBitStrobe(bitStrobe));

    // One register access; held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [11:0] idx,
                       input logic [7:0] wd, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address    <= {idx + 12'(FRAMER - 1) * FRAMER_STRIDE, 2'b00};
        avs_read       <= !wr;
        avs_write      <= wr;
        avs_writedata  <= {24'h000000, wd};
        avs_byteenable <= be;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata[7:0];
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        `CHK(n < 50, 1'b1)
    endtask

    // Wait, bounded, for the search flag or the pulse pin to reach a level
    task automatic waitSig(input bit pulse, input logic val, input int lim);
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while ((pulse ? pin.out : searchLive) !== val && n < lim);
        `CHK(n < lim, 1'b1)
    endtask

    // Cycles between two rising pulses on the sync pin
    task automatic period(input int expCyc);
        int t0;
        waitSig(1'b1, 1'b0, expCyc + 10);
        waitSig(1'b1, 1'b1, expCyc + 10);
        t0 = cyc;
        waitSig(1'b1, 1'b0, expCyc + 10);
        waitSig(1'b1, 1'b1, expCyc + 10);
        `CHK(cyc - t0, expCyc)
    endtask

    // Reset values, framer stride, refused writes
    task automatic testRegs();
        logic [11:0] idx [6] = '{CTRL_THREE_IDX, IO_CONFIG_IDX,
            RESYNC_CTRL_IDX, IRQ_MASK_IDX, LATCHED_IDX, LIVE_IDX};
        logic [7:0]  rv [6] = '{CTRL_THREE_RST, IO_CONFIG_RST,
            RESYNC_CTRL_RST, IRQ_MASK_RST, 8'h00, 8'h01};
        `CHK(pin.oe_n, 1'b1)
        `CHK(irqN, 1'b1)
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, idx[i], 8'h00, 4'h0);
            `CHK(rd, rv[i])
        end
        // Framer-one address is not ours; byte lane 0 off is ignored
        bus(1'b1, CTRL_THREE_IDX - FRAMER_STRIDE, 8'h04, 4'h1);
        bus(1'b1, CTRL_THREE_IDX, 8'h04, 4'h0);
        bus(1'b0, CTRL_THREE_IDX, 8'h00, 4'h0);
        `CHK(rd, 8'h00)
        bus(1'b0, CTRL_THREE_IDX - FRAMER_STRIDE, 8'h00, 4'h0);
        `CHK(rd, 8'h00)
        $display("test regs done");
    endtask

    // D4 alignment and frame pulse on the pin
    task automatic testD4();
        bus(1'b1, IO_CONFIG_IDX, 8'h04, 4'h1);
        @(negedge sys_clk);
        `CHK(pin.oe_n, 1'b0)
        bus(1'b0, IO_CONFIG_IDX, 8'h00, 4'h0);
        `CHK(rd, 8'h04)
        waitSig(1'b0, 1'b0, 40000);
        period(FRAME_CYC);
        $display("test d4 done");
    endtask

    // Loss latches, interrupts, and stays until read
    task automatic testLoss();
        bus(1'b1, IRQ_MASK_IDX, 8'h01, 4'h1);
        // Threshold zero: one bad F bit drops sync within a frame
        bus(1'b1, RESYNC_CTRL_IDX, 8'h00, 4'h1);
        badFraming <= 1'b1;
        waitSig(1'b0, 1'b1, FRAME_CYC + 8);
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        `CHK(irqN, 1'b0)
        @(posedge sys_clk);
        badFraming <= 1'b0;
        waitSig(1'b0, 1'b0, 40000);
        @(negedge sys_clk);
        `CHK(irqN, 1'b0)
        bus(1'b0, LATCHED_IDX, 8'h00, 4'h0);
        `CHK(rd, 8'h01)
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        `CHK(irqN, 1'b1)
        bus(1'b0, LATCHED_IDX, 8'h00, 4'h0);
        `CHK(rd, 8'h00)
        $display("test loss done");
    endtask

    // ESF search after a forced resync, masked loss, multiframe pulse
    task automatic testEsf();
        bus(1'b1, IRQ_MASK_IDX, 8'h00, 4'h1);
        // Switch formats just after an F bit, far from a frame end,
        // so the source and the block keep the same frame count
        waitSig(1'b1, 1'b1, FRAME_CYC + 10);
        bus(1'b1, CTRL_THREE_IDX, 8'h04, 4'h1);
        esfMode <= 1'b1;
        bus(1'b1, RESYNC_CTRL_IDX, 8'h05, 4'h1);
        waitSig(1'b0, 1'b1, 4);
        bus(1'b0, RESYNC_CTRL_IDX, 8'h00, 4'h0);
        `CHK(rd, 8'h01)
        waitSig(1'b0, 1'b0, 40000);
        bus(1'b0, LATCHED_IDX, 8'h00, 4'h0);
        `CHK(rd, 8'h01)
        `CHK(irqN, 1'b1)
        bus(1'b1, IO_CONFIG_IDX, 8'h05, 4'h1);
        period(24 * FRAME_CYC);
        $display("test esf done");
    endtask

    // Elastic store and interleaved mode hold the search idle
    task automatic testIdle();
        elasticOn <= 1'b1;
        bus(1'b0, LIVE_IDX, 8'h00, 4'h0);
        `CHK(rd, 8'h02)
        elasticOn      <= 1'b0;
        interleavedBus <= 1'b1;
        bus(1'b0, LIVE_IDX, 8'h00, 4'h0);
        `CHK(rd, 8'h02)
        interleavedBus <= 1'b0;
        waitSig(1'b0, 1'b1, 4);
        $display("test idle done");
    endtask

    // Verdict and end of run
    task automatic closeOut();
        $display("compared %0d mismatched %0d", nCompared, nMismatch);
        if (nMismatch == 0 && nCompared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Watchdog sized to the whole sequence
    initial begin
        repeat (99000) @(posedge sys_clk);
        nMismatch++;
        closeOut();
    end

    // Main sequence
    initial begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        testRegs();
        testD4();
        testLoss();
        testEsf();
        testIdle();
        closeOut();
    end
endmodule // t1_transmit_frame_synchronizer_bench
`default_nettype wire
